//--- core/clear_channel_assessment.sv
// Clear channel assessment registers, request control and status
`timescale 1ns/1ps
`include "cca_defines.svh"

// ****************************************************************
// Clear channel assessment top
// ****************************************************************
//
// Function
// - Config bits 6:5 pick the mode, 1 energy, 2 carrier, 3 both, reset 1.
// - Mode 1 calls the channel busy on any energy above the threshold.
// - Mode 3 needs a detected carrier whose energy also exceeds threshold.
// - Threshold bits 3:0 set the level at base plus two dB per count.
// - Writing 1 to config bit 7 starts an assessment only in basic mode while in receive.
// - The channel is watched for eight symbols, result ready at 140 us.
// - Status bit 7 is 0 while running and 1 once finished.
// - Status bit 6 is 1 for an idle channel and 0 for a busy one.
// - A status read clears the done and result bits, except one in the cycle the run finishes.
// - Status bits 4:0 show transceiver state, bit 5 zero, all read-only.
// - Config bits 4:0 hold a read-write channel number.
// - The strength base level of -91 dBm is the energy reference.
module clear_channel_assessment #(
    parameter int WINDOW_CYCLES = `EVAL_WINDOW_CYCLES,
    parameter int REPORT_CYCLES = `REPORT_DELAY_CYCLES
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_resetn,
    // Register port
    input wire logic [5:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_write,
    input wire logic i_reg_read,
    output logic [7:0] o_reg_rdata,
    // Transceiver context
    input wire logic [4:0] i_transceiver_state,
    input wire logic i_in_receive,
    input wire logic i_basic_mode,
    // Channel observations
    input wire logic [7:0] i_energy_level,
    input wire logic i_carrier_detect,
    // Outputs to the radio
    output logic [4:0] o_channel,
    output cca_pkg::assess_mode_t o_assess_mode,
    output logic o_assess_running
);
    import cca_pkg::*;

    // ************************************************************
    // Reset fields
    // ************************************************************
    // Split from the reset words so every field has its own width
    localparam logic [7:0] CONFIG_RESET =
        `RESET_PHY_CHANNEL_ASSESS_CONFIG;
    localparam logic REQUEST_RESET = CONFIG_RESET[`CFG_REQUEST_BIT];
    localparam logic [1:0] MODE_RESET =
        CONFIG_RESET[`CFG_MODE_MSB:`CFG_MODE_LSB];
    localparam logic [4:0] CHANNEL_RESET =
        CONFIG_RESET[`CFG_CHANNEL_MSB:`CFG_CHANNEL_LSB];
    localparam logic [7:0] THRESHOLD_RESET = `RESET_ENERGY_THRESHOLD;

    // ************************************************************
    // Address decode
    // ************************************************************
    function automatic logic hits(input logic [5:0] addr,
                                  input logic [5:0] target);
        hits = addr == target;
    endfunction : hits

    logic wr_config;
    logic wr_threshold;
    logic rd_status;
    logic rd_config;
    logic rd_threshold;

    assign wr_config = i_reg_write &&
        hits(i_reg_addr, `ADDR_PHY_CHANNEL_ASSESS_CONFIG);
    assign wr_threshold = i_reg_write &&
        hits(i_reg_addr, `ADDR_ENERGY_THRESHOLD);
    assign rd_status = i_reg_read &&
        hits(i_reg_addr, `ADDR_TRANSCEIVER_STATUS);
    assign rd_config = i_reg_read &&
        hits(i_reg_addr, `ADDR_PHY_CHANNEL_ASSESS_CONFIG);
    assign rd_threshold = i_reg_read &&
        hits(i_reg_addr, `ADDR_ENERGY_THRESHOLD);

    // ************************************************************
    // Configuration and threshold registers
    // ************************************************************
    logic assess_request_reg, assess_request_next;
    assess_mode_t assess_mode_reg, assess_mode_next;
    logic [4:0] channel_reg, channel_next;
    logic [7:0] energy_threshold_reg, energy_threshold_next;
    logic start_pulse;
    logic report_pulse;

    always_comb begin
        assess_mode_next = assess_mode_reg;
        channel_next = channel_reg;
        energy_threshold_next = energy_threshold_reg;
        if (wr_config) begin
            assess_mode_next = assess_mode_t'(
                i_reg_wdata[`CFG_MODE_MSB:`CFG_MODE_LSB]);
            channel_next =
                i_reg_wdata[`CFG_CHANNEL_MSB:`CFG_CHANNEL_LSB];
        end
        if (wr_threshold) begin
            // Upper bits are kept but steer nothing
            energy_threshold_next = i_reg_wdata;
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            assess_mode_reg <= assess_mode_t'(MODE_RESET);
            channel_reg <= CHANNEL_RESET;
            energy_threshold_reg <= THRESHOLD_RESET;
        end else begin
            assess_mode_reg <= assess_mode_next;
            channel_reg <= channel_next;
            energy_threshold_reg <= energy_threshold_next;
        end
    end

    // ************************************************************
    // Request flag
    // ************************************************************
    // Request reads back 1 only while an accepted run is live
    always_comb begin
        assess_request_next = assess_request_reg;
        if (start_pulse) begin
            assess_request_next = 1'b1;
        end else if (report_pulse) begin
            assess_request_next = 1'b0;
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            assess_request_reg <= REQUEST_RESET;
        end else begin
            assess_request_reg <= assess_request_next;
        end
    end

    // ************************************************************
    // Request acceptance
    // ************************************************************
    assess_state_t state_reg, state_next;
    logic request_written;
    logic request_allowed;
    logic in_window;
    logic window_sample;
    logic channel_busy;

    assign request_written = wr_config && i_reg_wdata[`CFG_REQUEST_BIT];
    // Automatic mode and non-receive states drop the request silently
    assign request_allowed = i_basic_mode && i_in_receive;
    // A request during a live run is ignored rather than restarting it
    assign start_pulse = request_written && request_allowed &&
        (state_reg == ST_IDLE);

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (start_pulse) begin
                    state_next = ST_EVAL;
                end
            end
            ST_EVAL: begin
                if (!in_window) begin
                    state_next = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (report_pulse) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ************************************************************
    // Timing and detection
    // ************************************************************
    cca_timer #(
        .WINDOW_CYCLES(WINDOW_CYCLES),
        .REPORT_CYCLES(REPORT_CYCLES)
    ) u_timer (
        .i_clock(i_clock),
        .i_resetn(i_resetn),
        .i_start(start_pulse),
        .o_in_window(in_window),
        .o_report(report_pulse)
    );

    // Eight symbols of samples; the tail waits for the report time
    assign window_sample = in_window && (state_reg == ST_EVAL);

    // Mode and threshold act live: a rewrite mid-run applies at once
    cca_detector u_detector (
        .i_clock(i_clock),
        .i_resetn(i_resetn),
        .i_clear(start_pulse),
        .i_sample(window_sample),
        .i_mode(assess_mode_reg),
        .i_threshold_level(
            energy_threshold_reg[`THR_LEVEL_MSB:`THR_LEVEL_LSB]),
        .i_energy_level(i_energy_level),
        .i_carrier_detect(i_carrier_detect),
        .o_busy(channel_busy)
    );

    // ************************************************************
    // Status flags
    // ************************************************************
    logic assess_done_reg, assess_done_next;
    logic assess_result_idle_reg, assess_result_idle_next;

    // Flags hold between runs so a slow poll still finds them
    always_comb begin
        assess_done_next = assess_done_reg;
        assess_result_idle_next = assess_result_idle_reg;
        if (report_pulse) begin
            // Finishing wins over a read in the same cycle
            assess_done_next = 1'b1;
            assess_result_idle_next = !channel_busy;
        end else if (start_pulse) begin
            assess_done_next = 1'b0;
            assess_result_idle_next = 1'b0;
        end else if (rd_status) begin
            assess_done_next = 1'b0;
            assess_result_idle_next = 1'b0;
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            assess_done_reg <= 1'b0;
            assess_result_idle_reg <= 1'b0;
        end else begin
            assess_done_reg <= assess_done_next;
            assess_result_idle_reg <= assess_result_idle_next;
        end
    end

    // ************************************************************
    // Read data
    // ************************************************************
    logic [7:0] rdata_reg, rdata_next;
    logic [7:0] status_word;
    logic [7:0] config_word;

    // Bit 5 reserved, reads zero; writes to status are ignored
    assign status_word = {assess_done_reg, assess_result_idle_reg,
        1'b0, i_transceiver_state};
    assign config_word = {assess_request_reg, assess_mode_reg,
        channel_reg};

    always_comb begin
        rdata_next = rdata_reg;
        if (rd_status) begin
            rdata_next = status_word;
        end else if (rd_config) begin
            rdata_next = config_word;
        end else if (rd_threshold) begin
            rdata_next = energy_threshold_reg;
        end else if (i_reg_read) begin
            rdata_next = 8'h00;
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            rdata_reg <= `RESET_TRANSCEIVER_STATUS;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign o_reg_rdata = rdata_reg;
    assign o_channel = channel_reg;
    assign o_assess_mode = assess_mode_reg;
    // Running spans the whole report delay, not just the window
    assign o_assess_running = state_reg != ST_IDLE;

endmodule : clear_channel_assessment

//--- core/cca_defines.svh
// Register map, field positions, reset values and timing of the assessor
`ifndef CCA_DEFINES_SVH
`define CCA_DEFINES_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define ADDR_TRANSCEIVER_STATUS 6'h01
`define ADDR_PHY_CHANNEL_ASSESS_CONFIG 6'h08
`define ADDR_ENERGY_THRESHOLD 6'h09

// ****************************************************************
// Field positions
// ****************************************************************
`define STAT_DONE_BIT 7
`define STAT_RESULT_BIT 6
`define STAT_STATE_MSB 4
`define STAT_STATE_LSB 0
`define CFG_REQUEST_BIT 7
`define CFG_MODE_MSB 6
`define CFG_MODE_LSB 5
`define CFG_CHANNEL_MSB 4
`define CFG_CHANNEL_LSB 0
`define THR_LEVEL_MSB 3
`define THR_LEVEL_LSB 0

// ****************************************************************
// Reset values
// ****************************************************************
`define RESET_TRANSCEIVER_STATUS 8'h00
`define RESET_PHY_CHANNEL_ASSESS_CONFIG 8'h2b
`define RESET_ENERGY_THRESHOLD 8'hc7

// ****************************************************************
// Levels and timing
// ****************************************************************
`define STRENGTH_BASE_LEVEL_DBM (-91)
`define THRESHOLD_STEP_DB 2
`define CLOCK_PERIOD_NS 25
`define SYMBOL_PERIOD_NS 16000
`define EVAL_SYMBOLS 8
`define REPORT_DELAY_NS 140000
// Window is a longest time: round down
`define EVAL_WINDOW_CYCLES \
    ((`EVAL_SYMBOLS * `SYMBOL_PERIOD_NS) / `CLOCK_PERIOD_NS)
// Report delay is a least time: round up
`define REPORT_DELAY_CYCLES \
    ((`REPORT_DELAY_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)

`endif

//--- core/cca_pkg.sv
// Types shared by the clear channel assessment files
package cca_pkg;

    typedef enum logic [1:0] {
        MODE_RESERVED = 2'h0,
        MODE_ENERGY = 2'h1,
        MODE_CARRIER = 2'h2,
        MODE_BOTH = 2'h3
    } assess_mode_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_EVAL = 3'h2,
        ST_WAIT = 3'h4
    } assess_state_t;

endpackage : cca_pkg

//--- core/cca_timer.sv
// Cycle counter marking the evaluation window and the report instant
`timescale 1ns/1ps
module cca_timer #(
    parameter int WINDOW_CYCLES = 5120,
    parameter int REPORT_CYCLES = 5600
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_resetn,
    // Control
    input wire logic i_start,
    // Timing marks
    output logic o_in_window,
    output logic o_report
);
    localparam int CW = $clog2(REPORT_CYCLES + 1);

    logic [CW-1:0] count_reg, count_next;
    logic run_reg, run_next;

    always_comb begin
        count_next = count_reg;
        run_next = run_reg;
        if (i_start) begin
            count_next = '0;
            run_next = 1'b1;
        end else if (run_reg) begin
            if (count_reg == CW'(REPORT_CYCLES - 1)) begin
                run_next = 1'b0;
            end else begin
                count_next = count_reg + CW'(1);
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            count_reg <= '0;
            run_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            run_reg <= run_next;
        end
    end

    assign o_in_window = run_reg && (count_reg < CW'(WINDOW_CYCLES));
    assign o_report = run_reg && (count_reg == CW'(REPORT_CYCLES - 1));

endmodule : cca_timer

//--- core/cca_detector.sv
// Per-sample busy decision and busy memory over the window
`timescale 1ns/1ps
module cca_detector (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_resetn,
    // Control
    input wire logic i_clear,
    input wire logic i_sample,
    input wire cca_pkg::assess_mode_t i_mode,
    input wire logic [3:0] i_threshold_level,
    // Channel observations
    input wire logic [7:0] i_energy_level,
    input wire logic i_carrier_detect,
    // Decision
    output logic o_busy
);
    import cca_pkg::*;

    // Energy is in dB above the base level, so the base cancels out
    function automatic logic energy_over(input logic [7:0] level,
                                         input logic [3:0] thr);
        logic [7:0] limit;
        limit = {3'h0, thr, 1'b0};
        energy_over = level > limit;
    endfunction : energy_over

    function automatic logic busy_now(input assess_mode_t mode,
                                      input logic over,
                                      input logic carrier);
        unique case (mode)
            MODE_CARRIER: busy_now = carrier;
            MODE_BOTH: busy_now = carrier && over;
            // Reserved code behaves as energy only
            default: busy_now = over;
        endcase
    endfunction : busy_now

    logic busy_reg, busy_next;
    logic hit;

    always_comb begin
        hit = busy_now(i_mode,
                       energy_over(i_energy_level, i_threshold_level),
                       i_carrier_detect);
        busy_next = busy_reg;
        if (i_clear) begin
            busy_next = 1'b0;
        end else if (i_sample && hit) begin
            busy_next = 1'b1;
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            busy_reg <= 1'b0;
        end else begin
            busy_reg <= busy_next;
        end
    end

    assign o_busy = busy_reg;

endmodule : cca_detector

//--- dv/cca_monitor.sv
// Port assertions for the clear channel assessment block
`timescale 1ns/1ps
module cca_monitor #(
    parameter int WINDOW_CYCLES = 5120,
    parameter int REPORT_CYCLES = 5600
) (
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic [5:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_write,
    input wire logic i_reg_read,
    input wire logic [7:0] o_reg_rdata,
    input wire logic [4:0] i_transceiver_state,
    input wire logic i_in_receive,
    input wire logic i_basic_mode,
    input wire logic [7:0] i_energy_level,
    input wire logic i_carrier_detect,
    input wire logic [4:0] o_channel,
    input wire cca_pkg::assess_mode_t o_assess_mode,
    input wire logic o_assess_running
);
    import cca_pkg::*;
    // ****************************************************************
    // Decode and run length counter
    // ****************************************************************
    logic wr_cfg, wr_thr, rd_stat, rd_thr, accept, rd_unmapped;
    logic [6:0] cfg_low;
    logic [15:0] run_cnt_reg, run_cnt_next;
    assign wr_cfg = i_reg_write && i_reg_addr == 6'h08;
    assign wr_thr = i_reg_write && i_reg_addr == 6'h09;
    assign rd_stat = i_reg_read && i_reg_addr == 6'h01;
    assign rd_thr = i_reg_read && i_reg_addr == 6'h09;
    assign rd_unmapped = i_reg_read && i_reg_addr != 6'h01
        && i_reg_addr != 6'h08 && i_reg_addr != 6'h09;
    assign accept = wr_cfg && i_reg_wdata[7] && i_basic_mode
        && i_in_receive && !o_assess_running;
    assign cfg_low = i_reg_wdata[6:0];
    always_comb begin
        run_cnt_next = run_cnt_reg;
        if (accept) begin
            run_cnt_next = 16'h0001;
        end else if (o_assess_running) begin
            run_cnt_next = run_cnt_reg + 16'h0001;
        end
    end
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            run_cnt_reg <= 16'h0000;
        end else begin
            run_cnt_reg <= run_cnt_next;
        end
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_resetn);
    a_run_start: assert property (accept |=> o_assess_running)
        else $error("accepted request did not start a run");
    a_run_refuse: assert property (wr_cfg && i_reg_wdata[7]
        && !o_assess_running && !(i_basic_mode && i_in_receive)
        |=> !o_assess_running) else $error("refused request started");
    a_run_length: assert property ($fell(o_assess_running)
        |-> run_cnt_reg == REPORT_CYCLES + 1) else $error("run length");
    a_done_low: assert property (rd_stat && o_assess_running
        |=> !o_reg_rdata[7]) else $error("done set while running");
    a_done_set: assert property (($fell(o_assess_running) && !rd_stat
        && !accept) ##1 rd_stat |=> o_reg_rdata[7])
        else $error("done missing after run");
    a_read_clear: assert property ((rd_stat && !o_assess_running)
        ##2 rd_stat |=> o_reg_rdata[7:6] == 2'b00)
        else $error("status flags not cleared by read");
    a_status_state: assert property (rd_stat
        |=> o_reg_rdata[5:0] == {1'b0, $past(i_transceiver_state)})
        else $error("status state field wrong");
    a_unmapped_zero: assert property (rd_unmapped
        |=> o_reg_rdata == 8'h00) else $error("unmapped read not zero");
    a_cfg_outputs: assert property (wr_cfg
        |=> {o_assess_mode, o_channel} == $past(cfg_low))
        else $error("mode or channel not updated");
    a_thr_readback: assert property (wr_thr ##1 !wr_thr ##1 rd_thr
        |=> o_reg_rdata == $past(i_reg_wdata, 3))
        else $error("threshold readback wrong");
endmodule : cca_monitor

bind clear_channel_assessment cca_monitor #(
    .WINDOW_CYCLES(WINDOW_CYCLES), .REPORT_CYCLES(REPORT_CYCLES)
) u_cca_monitor (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_write(i_reg_write),
    .i_reg_read(i_reg_read), .o_reg_rdata(o_reg_rdata),
    .i_transceiver_state(i_transceiver_state),
    .i_in_receive(i_in_receive), .i_basic_mode(i_basic_mode),
    .i_energy_level(i_energy_level), .i_carrier_detect(i_carrier_detect),
    .o_channel(o_channel), .o_assess_mode(o_assess_mode),
    .o_assess_running(o_assess_running)
);

//--- dv/host_model.sv
// Host software model driving the strobe register port
`timescale 1ns/1ps
module host_model (
    // Clock
    input wire logic i_clock,
    // Register port
    output logic [5:0] o_reg_addr,
    output logic [7:0] o_reg_wdata,
    output logic o_reg_write,
    output logic o_reg_read,
    input wire logic [7:0] i_reg_rdata
);
    // ****************************************************************
    // One access per task, two cycles apart
    // ****************************************************************
    initial begin
        o_reg_addr = 6'h00;
        o_reg_wdata = 8'h00;
        o_reg_write = 1'b0;
        o_reg_read = 1'b0;
    end
    task automatic access(input logic w, input logic [5:0] a,
                          input logic [7:0] d);
        @(negedge i_clock);
        o_reg_addr = a;
        o_reg_wdata = d;
        o_reg_write = w;
        o_reg_read = !w;
        @(negedge i_clock);
        o_reg_write = 1'b0;
        o_reg_read = 1'b0;
        // Released lines show garbage, never the old value
        o_reg_addr = ~a;
        o_reg_wdata = ~d;
    endtask : access
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        access(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        access(1'b0, a, 8'h00);
        @(posedge i_clock);
        #1;
        d = i_reg_rdata;
    endtask : rd
endmodule : host_model

//--- dv/tb.sv
// Self-checking bench for the clear channel assessment block
`timescale 1ns/1ps
module tb;
    import cca_pkg::*;
    logic i_clock, i_resetn, reg_write, reg_read, in_rx, basic, carrier;
    logic running, busy;
    logic [5:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, energy, thr, d;
    logic [4:0] trx_state, channel, ch;
    logic [1:0] mode;
    assess_mode_t mode_out;
    int num_errors, n_tests, seed, k;
    logic [7:0] exp_q[$];
    clear_channel_assessment #(.WINDOW_CYCLES(8), .REPORT_CYCLES(12))
    u_clear_channel_assessment (
        .i_clock(i_clock), .i_resetn(i_resetn), .i_reg_addr(reg_addr),
        .i_reg_wdata(reg_wdata), .i_reg_write(reg_write),
        .i_reg_read(reg_read), .o_reg_rdata(reg_rdata),
        .i_transceiver_state(trx_state), .i_in_receive(in_rx),
        .i_basic_mode(basic), .i_energy_level(energy),
        .i_carrier_detect(carrier), .o_channel(channel),
        .o_assess_mode(mode_out), .o_assess_running(running));
    host_model u_host (.i_clock(i_clock), .o_reg_addr(reg_addr),
        .o_reg_wdata(reg_wdata), .o_reg_write(reg_write),
        .o_reg_read(reg_read), .i_reg_rdata(reg_rdata));
    // ****************************************************************
    // Checking and closing
    // ****************************************************************
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] e);
        n_tests++;
        if (got !== e) begin
            num_errors++;
            $display("[ERR] %0t reg %h exp %h", $time, got, e);
        end
    endtask : chk_reg
    task automatic chk_out(input logic [6:0] got, input logic [6:0] e);
        n_tests++;
        if (got !== e) begin
            num_errors++;
            $display("[ERR] %0t out %h exp %h", $time, got, e);
        end
    endtask : chk_out
    task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
        logic [7:0] v;
        u_host.rd(a, v);
        chk_reg(v, e);
    endtask : rd_chk
    task automatic conclude();
        if (num_errors == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude
    always #12.5 i_clock = ~i_clock;
    initial begin
        repeat (100000) @(posedge i_clock);
        num_errors++;
        conclude();
    end
    initial begin
        seed = 32'hd90a;
        i_clock = 1'b0;
        i_resetn = 1'b0;
        {in_rx, basic, carrier} = 3'b110;
        energy = 8'h00;
        trx_state = 5'h06;
        repeat (12) @(negedge i_clock);
        i_resetn = 1'b1;
        rd_chk(6'h08, 8'h2b);
        rd_chk(6'h09, 8'hc7);
        rd_chk(6'h2a, 8'h00);
        chk_out({mode_out, channel}, 7'h2b);
        u_host.wr(6'h01, 8'hff);
        rd_chk(6'h01, 8'h06);
        for (int i = 0; i < 16; i++) begin
            @(negedge i_clock);
            mode = 2'(i);
            thr = 8'($random(seed));
            ch = 5'($random(seed));
            trx_state = 5'($random(seed));
            carrier = 1'($random(seed));
            energy = {3'h0, thr[3:0], 1'b0} + 8'($random(seed) & 1);
            busy = energy > 2 * thr[3:0];
            if (mode == 2'h2) busy = carrier;
            if (mode == 2'h3) busy = busy && carrier;
            exp_q.push_back({1'b1, !busy, 1'b0, trx_state});
            u_host.wr(6'h09, thr);
            rd_chk(6'h09, thr);
            u_host.wr(6'h08, {1'b1, mode, ch});
            chk_out({mode_out, channel}, {mode, ch});
            chk_out({6'h00, running}, 7'h01);
            rd_chk(6'h08, {1'b1, mode, ch});
            rd_chk(6'h01, {3'h0, trx_state});
            // Busy seen early must be remembered to the end
            @(negedge i_clock);
            if (i[0]) {energy, carrier} = 9'h000;
            // Shifted polls land one read on the report cycle
            if (i[1]) @(negedge i_clock);
            d = 8'h00;
            k = 0;
            while (d[7] !== 1'b1 && k < 20) begin
                u_host.rd(6'h01, d);
                k++;
            end
            if (d[7] !== 1'b1) begin
                num_errors++;
                conclude();
            end
            chk_reg(d, exp_q.pop_front());
            rd_chk(6'h01, {3'h0, trx_state});
        end
        for (int j = 0; j < 2; j++) begin
            @(negedge i_clock);
            in_rx = 1'(j);
            basic = !in_rx;
            u_host.wr(6'h08, 8'hc3 ^ 8'(j));
            rd_chk(6'h08, 8'h43 ^ 8'(j));
            chk_out({6'h00, running}, 7'h00);
            repeat (14) @(negedge i_clock);
            rd_chk(6'h01, {3'h0, trx_state});
        end
        // Reset in mid-run aborts the run and restores the defaults
        @(negedge i_clock);
        {in_rx, basic} = 2'b11;
        u_host.wr(6'h08, 8'hab);
        chk_out({6'h00, running}, 7'h01);
        i_resetn = 1'b0;
        repeat (2) @(negedge i_clock);
        i_resetn = 1'b1;
        chk_out({6'h00, running}, 7'h00);
        chk_reg(reg_rdata, 8'h00);
        rd_chk(6'h08, 8'h2b);
        rd_chk(6'h09, 8'hc7);
        rd_chk(6'h01, {3'h0, trx_state});
        conclude();
    end
endmodule : tb
